/* File: htm_pkg.sv */
// Constants and types of the transducer register bank
// Overview of operation
// - ID answer: 11h, 08h, identifier, state, six variable bytes, CRC.
// - 16-bit register bits run b0 (LSB) to b15 (MSB).
// - 32-bit registers hold IEEE-754 floats, sent B3, B2, B1, B0.
// - Mirror 6000..6025: low word first, B1 B0 B3 B2.
// - Mirror 7000..7025: high word first, B3 B2 B1 B0.
// - 7500..7512 are read-only 32-bit measurement registers.
// - Mirrors equal the 32-bit registers, read-only, two words per value.
// - Addresses decode zero-based; one-based masters add one themselves.
// - 4000..4011 each hold one 16-bit integer.
// - Status one means event present; b14 calibration, b13 parameters.
// - Status b15 set by supply reset, cleared by writing 8000h.
// - Status b10 set when extremes erased, cleared by writing 400h.
// - Status b9 reads one while the emergency jumper forces link settings.
// - Status b7 set on sensing element communication failure.
// - Status b2 set when averaging time is exceeded.
// - Writing 1 to 4006 erases minima and maxima; 0 changes nothing.
package htm_pkg;

   // 16-bit register numbers, zero-based
   localparam logic [15:0] ADDR_IDENT = 16'h0fa0;
   localparam logic [15:0] ADDR_NODE = 16'h0fa1;
   localparam logic [15:0] ADDR_BAUD = 16'h0fa2;
   localparam logic [15:0] ADDR_FMT = 16'h0fa3;
   localparam logic [15:0] ADDR_COMMIT = 16'h0fa4;
   localparam logic [15:0] ADDR_AVG = 16'h0fa5;
   localparam logic [15:0] ADDR_XCLR = 16'h0fa6;
   localparam logic [15:0] ADDR_STATUS = 16'h0fa7;
   localparam logic [15:0] ADDR_FWREV = 16'h0fa8;
   localparam logic [15:0] ADDR_RESTORE = 16'h0fa9;
   localparam logic [15:0] ADDR_SPARE_A = 16'h0faa;
   localparam logic [15:0] ADDR_SPARE_B = 16'h0fab;

   // Float areas
   localparam logic [15:0] MIRROR_LO_BASE = 16'h1770;
   localparam logic [15:0] MIRROR_HI_BASE = 16'h1b58;
   localparam logic [15:0] FLOAT_BASE = 16'h1d4c;
   localparam int NUM_FLOAT = 13;

   // Status bit positions
   localparam int ST_SUPPLY_RESET = 15;
   localparam int ST_CALIB_ERR = 14;
   localparam int ST_PARAM_ERR = 13;
   localparam int ST_XTREME_ERASED = 10;
   localparam int ST_TEMP_COMM = 9;
   localparam int ST_SENSOR_ERR = 7;
   localparam int ST_AVG_OVERRUN = 2;
   localparam logic [15:0] CLR_SUPPLY_RESET = 16'h8000;
   localparam logic [15:0] CLR_XTREME_ERASED = 16'h0400;

   // Value ranges
   localparam logic [15:0] NODE_MIN = 16'h0001;
   localparam logic [15:0] NODE_MAX = 16'h00f7;
   localparam logic [15:0] AVG_MIN = 16'h0006;
   localparam logic [15:0] AVG_MAX = 16'h0e10;
   localparam logic [15:0] FLAG_ONE = 16'h0001;

   typedef enum logic [2:0] {
      HTM_BAUD_4800 = 3'b000,
      HTM_BAUD_9600 = 3'b001,
      HTM_BAUD_19200 = 3'b010,
      HTM_BAUD_38400 = 3'b011,
      HTM_BAUD_57600 = 3'b100
   } htm_baud_type;

   typedef enum logic [1:0] {
      HTM_FMT_8N1 = 2'b00,
      HTM_FMT_8N2 = 2'b01,
      HTM_FMT_8E1 = 2'b10,
      HTM_FMT_8O1 = 2'b11
   } htm_fmt_type;

   // Factory defaults
   localparam logic [7:0] DEF_NODE = 8'h01;
   localparam htm_baud_type DEF_BAUD = HTM_BAUD_9600;
   localparam htm_fmt_type DEF_FMT = HTM_FMT_8N2;
   localparam logic [15:0] DEF_AVG = 16'h000a;

   // Settings forced by the emergency jumper
   localparam logic [7:0] JMP_NODE = 8'hf7;
   localparam htm_baud_type JMP_BAUD = HTM_BAUD_9600;
   localparam htm_fmt_type JMP_FMT = HTM_FMT_8N2;

   // Answers
   localparam logic [7:0] EXC_NONE = 8'h00;
   localparam logic [7:0] EXC_BAD_ADDR = 8'h02;
   localparam logic [7:0] EXC_BAD_VALUE = 8'h03;
   localparam logic [7:0] ID_FUNC = 8'h11;
   localparam logic [7:0] ID_COUNT = 8'h08;
   localparam logic [3:0] ID_LEN = 4'ha;
   localparam logic [7:0] STATE_RUN = 8'hff;
   localparam logic [7:0] STATE_FAULT = 8'h00;

endpackage

/* File: htm_ident_seq.sv */
// Byte sequencer for the identification answer
`timescale 1ns/1ns
module htm_ident_seq (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [7:0] i_ident,
   input wire logic [7:0] i_state,
   input wire logic [47:0] i_var_bytes,
   output logic o_valid,
   output logic [7:0] o_byte,
   output logic o_busy
);
   import htm_pkg::*;

   logic [3:0] idx_reg;
   logic [3:0] idx_next;
   logic busy_reg;
   logic busy_next;
   logic valid_reg;
   logic [7:0] byte_reg;
   logic [7:0] state_reg;
   logic [7:0] sel_byte;
   logic last;

   // State byte caught at start keeps the answer consistent
   assign last = (idx_reg == ID_LEN - 4'h1);
   assign busy_next = busy_reg ? !last : i_start;
   assign idx_next = busy_reg ? (last ? 4'h0 : idx_reg + 4'h1) : 4'h0;
   assign sel_byte = (idx_reg == 4'h0) ? ID_FUNC :
                     (idx_reg == 4'h1) ? ID_COUNT :
                     (idx_reg == 4'h2) ? i_ident :
                     (idx_reg == 4'h3) ? state_reg :
                     i_var_bytes[8'(47 - 8 * (32'(idx_reg) - 4)) -: 8];

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         idx_reg <= 4'h0;
         busy_reg <= 1'b0;
         valid_reg <= 1'b0;
         byte_reg <= 8'h00;
         state_reg <= 8'h00;
      end else begin
         idx_reg <= idx_next;
         busy_reg <= busy_next;
         valid_reg <= busy_reg;
         byte_reg <= busy_reg ? sel_byte : 8'h00;
         if (!busy_reg && i_start) begin
            state_reg <= i_state;
         end
      end
   end

   assign o_valid = valid_reg;
   assign o_byte = byte_reg;
   assign o_busy = busy_reg;
endmodule

/* File: htm_regs.sv */
// Register bank of the humidity transducer
`timescale 1ns/1ns
module htm_regs #(
   parameter int NUM_FLOAT = htm_pkg::NUM_FLOAT,
   parameter logic [15:0] IDENT_CODE = 16'h005a,
   parameter logic [15:0] FW_REVISION = 16'h0064,
   parameter logic [47:0] ID_VAR_BYTES = 48'h0102_0304_0506
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic i_id_req,
   input wire logic [NUM_FLOAT*32-1:0] i_float_bank,
   input wire logic i_calib_err,
   input wire logic i_param_err,
   input wire logic i_sensor_comm_err,
   input wire logic i_avg_overrun,
   input wire logic i_temp_comm_jumper,
   output logic o_ack,
   output logic [31:0] o_rdata,
   output logic o_rdata_wide,
   output logic [7:0] o_exc,
   output logic o_id_valid,
   output logic [7:0] o_id_byte,
   output logic [7:0] o_node_addr,
   output htm_pkg::htm_baud_type o_baud_sel,
   output htm_pkg::htm_fmt_type o_frame_fmt,
   output logic [15:0] o_avg_period,
   output logic o_extremes_clear,
   output logic o_temp_params_active
);
   import htm_pkg::*;

   localparam logic [15:0] SPAN16 = 16'(2 * NUM_FLOAT);
   localparam logic [15:0] SPAN32 = 16'(NUM_FLOAT);

   // Reset release and pin synchroniser
   logic rst_meta_reg;
   logic rst_n_reg;
   logic jmp_meta_reg;
   logic jmp_sync_reg;

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_meta_reg <= 1'b0;
         rst_n_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_n_reg <= rst_meta_reg;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         jmp_meta_reg <= 1'b0;
         jmp_sync_reg <= 1'b0;
      end else begin
         jmp_meta_reg <= i_temp_comm_jumper;
         jmp_sync_reg <= jmp_meta_reg;
      end
   end

   // Float values as an array, one entry per measured quantity
   logic [31:0] float_arr [NUM_FLOAT];
   genvar g;
   generate
      for (g = 0; g < NUM_FLOAT; g = g + 1) begin : g_float
         assign float_arr[g] = i_float_bank[g*32 +: 32];
      end
   endgenerate

   // Address decode; register numbers are used as given, zero-based
   logic [15:0] lo_off;
   logic [15:0] hi_off;
   logic [15:0] fl_off;
   logic in_lo;
   logic in_hi;
   logic in_fl;
   logic in_cfg;
   logic [15:0] mir_off;
   logic [3:0] fidx;
   logic [31:0] fval;
   logic mir_low_first;

   assign lo_off = i_addr - MIRROR_LO_BASE;
   assign hi_off = i_addr - MIRROR_HI_BASE;
   assign fl_off = i_addr - FLOAT_BASE;
   assign in_lo = (i_addr >= MIRROR_LO_BASE) && (lo_off < SPAN16);
   assign in_hi = (i_addr >= MIRROR_HI_BASE) && (hi_off < SPAN16);
   assign in_fl = (i_addr >= FLOAT_BASE) && (fl_off < SPAN32);
   assign in_cfg = (i_addr >= ADDR_IDENT) && (i_addr <= ADDR_SPARE_B);
   assign mir_off = in_lo ? lo_off : hi_off;
   assign fidx = in_fl ? fl_off[3:0] : mir_off[4:1];
   assign fval = float_arr[fidx];
   assign mir_low_first = in_lo;

   // Mirror word selection: even address gives the first word of the pair
   logic mir_take_hi;
   logic [15:0] mir_word;
   assign mir_take_hi = mir_low_first ? mir_off[0] : !mir_off[0];
   assign mir_word = mir_take_hi ? fval[31:16] : fval[15:0];

   // Configuration state
   logic [7:0] node_reg;
   htm_baud_type baud_reg;
   htm_fmt_type fmt_reg;
   logic [7:0] act_node_reg;
   htm_baud_type act_baud_reg;
   htm_fmt_type act_fmt_reg;
   logic [15:0] avg_reg;
   logic st15_reg;
   logic st10_reg;
   logic [15:0] lvl_reg;

   // Status word, b0 is the least significant bit
   logic [15:0] status_word;
   logic [15:0] lvl_next;
   assign lvl_next = (16'(i_calib_err) << ST_CALIB_ERR) |
                     (16'(i_param_err) << ST_PARAM_ERR) |
                     (16'(jmp_sync_reg) << ST_TEMP_COMM) |
                     (16'(i_sensor_comm_err) << ST_SENSOR_ERR) |
                     (16'(i_avg_overrun) << ST_AVG_OVERRUN);
   assign status_word = lvl_reg | (16'(st15_reg) << ST_SUPPLY_RESET) |
                        (16'(st10_reg) << ST_XTREME_ERASED);

   // Write decode
   logic wr;
   logic w_node;
   logic w_baud;
   logic w_fmt;
   logic w_commit;
   logic w_avg;
   logic w_xclr;
   logic w_status;
   logic w_restore;
   logic is_flag;
   logic val_ok;
   logic ro_hit;
   logic known;

   assign wr = i_req && i_we;
   assign w_node = wr && (i_addr == ADDR_NODE);
   assign w_baud = wr && (i_addr == ADDR_BAUD);
   assign w_fmt = wr && (i_addr == ADDR_FMT);
   assign w_commit = wr && (i_addr == ADDR_COMMIT);
   assign w_avg = wr && (i_addr == ADDR_AVG);
   assign w_xclr = wr && (i_addr == ADDR_XCLR);
   assign w_status = wr && (i_addr == ADDR_STATUS);
   assign w_restore = wr && (i_addr == ADDR_RESTORE);
   assign is_flag = (i_wdata <= FLAG_ONE);
   assign val_ok = (w_node && (i_wdata >= NODE_MIN) && (i_wdata <= NODE_MAX)) ||
                   (w_baud && (i_wdata <= 16'(HTM_BAUD_57600))) ||
                   (w_fmt && (i_wdata <= 16'(HTM_FMT_8O1))) ||
                   (w_avg && (i_wdata >= AVG_MIN) && (i_wdata <= AVG_MAX)) ||
                   ((w_commit || w_xclr || w_restore) && is_flag) ||
                   w_status || (i_addr == ADDR_SPARE_A) || (i_addr == ADDR_SPARE_B);
   assign ro_hit = in_lo || in_hi || in_fl || (i_addr == ADDR_IDENT) ||
                   (i_addr == ADDR_FWREV);
   assign known = in_lo || in_hi || in_fl || in_cfg;

   // A rejected write leaves every register as it was
   logic do_node;
   logic do_baud;
   logic do_fmt;
   logic do_avg;
   logic do_commit;
   logic do_erase;
   logic do_restore;
   assign do_node = w_node && val_ok;
   assign do_baud = w_baud && val_ok;
   assign do_fmt = w_fmt && val_ok;
   assign do_avg = w_avg && val_ok;
   assign do_commit = w_commit && (i_wdata == FLAG_ONE);
   assign do_erase = w_xclr && (i_wdata == FLAG_ONE);
   assign do_restore = w_restore && (i_wdata == FLAG_ONE);

   // Next values of the configuration
   logic [7:0] node_next;
   htm_baud_type baud_next;
   htm_fmt_type fmt_next;
   logic [7:0] act_node_next;
   htm_baud_type act_baud_next;
   htm_fmt_type act_fmt_next;
   logic [15:0] avg_next;
   logic st15_next;
   logic st10_next;

   assign node_next = do_restore ? DEF_NODE : do_node ? i_wdata[7:0] : node_reg;
   assign baud_next = do_restore ? DEF_BAUD : do_baud ? htm_baud_type'(i_wdata[2:0]) : baud_reg;
   assign fmt_next = do_restore ? DEF_FMT : do_fmt ? htm_fmt_type'(i_wdata[1:0]) : fmt_reg;
   assign avg_next = do_restore ? DEF_AVG : do_avg ? i_wdata : avg_reg;
   assign act_node_next = do_restore ? DEF_NODE : do_commit ? node_reg : act_node_reg;
   assign act_baud_next = do_restore ? DEF_BAUD : do_commit ? baud_reg : act_baud_reg;
   assign act_fmt_next = do_restore ? DEF_FMT : do_commit ? fmt_reg : act_fmt_reg;
   // Only the exact value clears a flag; a set event beats a clear
   assign st15_next = st15_reg && !(w_status && (i_wdata == CLR_SUPPLY_RESET));
   assign st10_next = do_erase ||
                      (st10_reg && !(w_status && (i_wdata == CLR_XTREME_ERASED)));

   always_ff @(posedge i_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         node_reg <= DEF_NODE;
         baud_reg <= DEF_BAUD;
         fmt_reg <= DEF_FMT;
         act_node_reg <= DEF_NODE;
         act_baud_reg <= DEF_BAUD;
         act_fmt_reg <= DEF_FMT;
         avg_reg <= DEF_AVG;
         st15_reg <= 1'b1;
         st10_reg <= 1'b0;
         lvl_reg <= 16'h0000;
      end else begin
         node_reg <= node_next;
         baud_reg <= baud_next;
         fmt_reg <= fmt_next;
         act_node_reg <= act_node_next;
         act_baud_reg <= act_baud_next;
         act_fmt_reg <= act_fmt_next;
         avg_reg <= avg_next;
         st15_reg <= st15_next;
         st10_reg <= st10_next;
         lvl_reg <= lvl_next;
      end
   end

   // Read multiplexer; action registers read back as zero
   logic [15:0] cfg_word;
   logic [31:0] rdata_next;
   logic [7:0] exc_next;
   assign cfg_word = (i_addr == ADDR_IDENT) ? IDENT_CODE :
                     (i_addr == ADDR_NODE) ? {8'h00, node_reg} :
                     (i_addr == ADDR_BAUD) ? {13'h0000, baud_reg} :
                     (i_addr == ADDR_FMT) ? {14'h0000, fmt_reg} :
                     (i_addr == ADDR_AVG) ? avg_reg :
                     (i_addr == ADDR_STATUS) ? status_word :
                     (i_addr == ADDR_FWREV) ? FW_REVISION : 16'h0000;
   assign rdata_next = (!i_req || i_we) ? 32'h0000_0000 :
                       in_fl ? fval :
                       (in_lo || in_hi) ? {16'h0000, mir_word} :
                       in_cfg ? {16'h0000, cfg_word} : 32'h0000_0000;
   assign exc_next = !known ? EXC_BAD_ADDR :
                     (i_we && ro_hit) ? EXC_BAD_ADDR :
                     (i_we && !val_ok) ? EXC_BAD_VALUE : EXC_NONE;

   // Active link settings; the jumper overrides without touching stored values
   logic [7:0] link_node;
   htm_baud_type link_baud;
   htm_fmt_type link_fmt;
   assign link_node = jmp_sync_reg ? JMP_NODE : act_node_reg;
   assign link_baud = jmp_sync_reg ? JMP_BAUD : act_baud_reg;
   assign link_fmt = jmp_sync_reg ? JMP_FMT : act_fmt_reg;

   logic ack_reg;
   logic [31:0] rdata_reg;
   logic wide_reg;
   logic [7:0] exc_reg;
   logic [7:0] o_node_reg;
   htm_baud_type o_baud_reg;
   htm_fmt_type o_fmt_reg;
   logic [15:0] o_avg_reg;
   logic xclr_reg;
   logic tmp_reg;

   always_ff @(posedge i_clk or negedge rst_n_reg) begin
      if (!rst_n_reg) begin
         ack_reg <= 1'b0;
         rdata_reg <= 32'h0000_0000;
         wide_reg <= 1'b0;
         exc_reg <= EXC_NONE;
         o_node_reg <= DEF_NODE;
         o_baud_reg <= DEF_BAUD;
         o_fmt_reg <= DEF_FMT;
         o_avg_reg <= DEF_AVG;
         xclr_reg <= 1'b0;
         tmp_reg <= 1'b0;
      end else begin
         ack_reg <= i_req;
         rdata_reg <= rdata_next;
         wide_reg <= i_req && !i_we && in_fl;
         exc_reg <= i_req ? exc_next : EXC_NONE;
         o_node_reg <= link_node;
         o_baud_reg <= link_baud;
         o_fmt_reg <= link_fmt;
         o_avg_reg <= avg_reg;
         xclr_reg <= do_erase;
         tmp_reg <= jmp_sync_reg;
      end
   end

   // Identification answer
   logic [7:0] dev_state;
   assign dev_state = (lvl_reg[ST_CALIB_ERR] || lvl_reg[ST_PARAM_ERR] ||
                       lvl_reg[ST_SENSOR_ERR]) ? STATE_FAULT : STATE_RUN;

   htm_ident_seq u_ident (
      .i_clk(i_clk),
      .i_rst_n(rst_n_reg),
      .i_start(i_id_req),
      .i_ident(IDENT_CODE[7:0]),
      .i_state(dev_state),
      .i_var_bytes(ID_VAR_BYTES),
      .o_valid(o_id_valid),
      .o_byte(o_id_byte),
      .o_busy()
   );

   assign o_ack = ack_reg;
   assign o_rdata = rdata_reg;
   assign o_rdata_wide = wide_reg;
   assign o_exc = exc_reg;
   assign o_node_addr = o_node_reg;
   assign o_baud_sel = o_baud_reg;
   assign o_frame_fmt = o_fmt_reg;
   assign o_avg_period = o_avg_reg;
   assign o_extremes_clear = xclr_reg;
   assign o_temp_params_active = tmp_reg;
endmodule

/* File: htm_regs_assertions.sv */
// Port-level checks of the transducer register bank
`timescale 1ns/1ns
module htm_regs_assertions #(
   parameter int NUM_FLOAT = htm_pkg::NUM_FLOAT
) (
   input wire logic i_clk,
   input wire logic i_arst_n,
   input wire logic i_req,
   input wire logic i_we,
   input wire logic [15:0] i_addr,
   input wire logic [15:0] i_wdata,
   input wire logic [NUM_FLOAT*32-1:0] i_float_bank,
   input wire logic o_ack,
   input wire logic [31:0] o_rdata,
   input wire logic o_rdata_wide,
   input wire logic [7:0] o_exc,
   input wire logic o_id_valid,
   input wire logic [7:0] o_id_byte,
   input wire logic [7:0] o_node_addr,
   input wire htm_pkg::htm_baud_type o_baud_sel,
   input wire logic o_extremes_clear,
   input wire logic o_temp_params_active
);
   import htm_pkg::*;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   wire logic rd_now = i_req && !i_we;
   wire logic wr_now = i_req && i_we;
   wire logic in_f32 = (i_addr - FLOAT_BASE) < 16'd13;
   wire logic in_mir = (i_addr - MIRROR_LO_BASE) < 16'd26 || (i_addr - MIRROR_HI_BASE) < 16'd26;
   property p_ack; i_req |=> o_ack; endproperty
   a_ack: assert property (p_ack) else $error("ack missing after request");
   property p_wide; rd_now && in_f32 |=> o_rdata_wide && o_exc == EXC_NONE; endproperty
   a_wide: assert property (p_wide) else $error("wide read not flagged");
   property p_f32; rd_now && i_addr == FLOAT_BASE |=> o_rdata == $past(i_float_bank[31:0]); endproperty
   a_f32: assert property (p_f32) else $error("float word wrong");
   property p_hi; rd_now && i_addr == MIRROR_HI_BASE |=> o_rdata == {16'h0, $past(i_float_bank[31:16])} && !o_rdata_wide; endproperty
   a_hi: assert property (p_hi) else $error("high-first mirror wrong");
   property p_lo; rd_now && i_addr == MIRROR_LO_BASE |=> o_rdata == {16'h0, $past(i_float_bank[15:0])}; endproperty
   a_lo: assert property (p_lo) else $error("low-first mirror wrong");
   property p_ro; wr_now && (in_f32 || in_mir) |=> o_exc == EXC_BAD_ADDR; endproperty
   a_ro: assert property (p_ro) else $error("float area write not refused");
   property p_id; $rose(o_id_valid) |-> o_id_byte == ID_FUNC ##1 o_id_byte == ID_COUNT; endproperty
   a_id: assert property (p_id) else $error("id header wrong");
   property p_idlen; $rose(o_id_valid) |-> o_id_valid [*8] ##1 o_id_valid [*2] ##1 !o_id_valid; endproperty
   a_idlen: assert property (p_idlen) else $error("id length wrong");
   property p_xclr; wr_now && i_addr == ADDR_XCLR && i_wdata == FLAG_ONE |-> ##[1:2] o_extremes_clear; endproperty
   a_xclr: assert property (p_xclr) else $error("erase pulse missing");
   property p_xkeep; wr_now && i_addr == ADDR_XCLR && i_wdata == 16'h0 |=> !o_extremes_clear ##1 !o_extremes_clear; endproperty
   a_xkeep: assert property (p_xkeep) else $error("erase on zero");
   property p_hold; wr_now && i_addr == ADDR_NODE && !o_temp_params_active |=> $stable(o_node_addr) [*2]; endproperty
   a_hold: assert property (p_hold) else $error("address changed without commit");
   property p_range; o_node_addr >= 8'h01 && o_node_addr <= 8'hf7 && o_baud_sel <= HTM_BAUD_57600; endproperty
   a_range: assert property (p_range) else $error("link setting out of range");
   property p_jmp; o_temp_params_active |-> ##[0:1] o_node_addr == JMP_NODE; endproperty
   a_jmp: assert property (p_jmp) else $error("jumper address not forced");
   c_id: cover property ($rose(o_id_valid));
   c_wide: cover property (o_ack && o_rdata_wide);
   c_jmp: cover property ($rose(o_temp_params_active));
   c_ref: cover property (o_ack && o_exc == EXC_BAD_VALUE);
endmodule

/* File: htm_master_model.sv */
// Frame handler side: one register request per number
`timescale 1ns/1ns
module htm_master_model (
   input wire logic i_clk,
   output logic o_req,
   output logic o_we,
   output logic [15:0] o_addr,
   output logic [15:0] o_wdata,
   output logic o_id_req
);
   initial {o_req, o_we, o_addr, o_wdata, o_id_req} = '0;
   // Numbers are physical, zero-based
   task automatic access(input logic we, input logic [15:0] a, input logic [15:0] d);
      o_req = 1'b1;
      o_we = we;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk);
      #1;
   endtask
   // Released lines show inverted junk
   task automatic idle();
      o_req = 1'b0;
      o_we = ~o_we;
      o_addr = ~o_addr;
      o_wdata = ~o_wdata;
      @(posedge i_clk);
      #1;
   endtask
   task automatic ident();
      o_id_req = 1'b1;
      @(posedge i_clk);
      #1;
      o_id_req = 1'b0;
   endtask
endmodule

/* File: humidity_transducer_modbus_regs_bench.sv */
// Self-checking bench of the transducer register bank
`timescale 1ns/1ns
module humidity_transducer_modbus_regs_bench;
   import htm_pkg::*;
   localparam logic [15:0] IDC = 16'h0033; // Arbitrary identifier value
   localparam logic [15:0] FWR = 16'h0064;
   localparam logic [47:0] VARB = 48'ha1b2c3d4e5f6;
   logic i_clk, i_arst_n, i_req, i_we, i_id_req, o_ack, o_rdata_wide, o_id_valid;
   logic i_calib_err, i_param_err, i_sensor_comm_err, i_avg_overrun, i_temp_comm_jumper;
   logic o_extremes_clear, o_temp_params_active;
   logic [15:0] i_addr, i_wdata, o_avg_period;
   logic [NUM_FLOAT*32-1:0] i_float_bank;
   logic [31:0] o_rdata;
   logic [7:0] o_exc, o_id_byte, o_node_addr;
   htm_baud_type o_baud_sel;
   htm_fmt_type o_frame_fmt;
   logic [40:0] exp_q[$];
   logic [7:0] id_q[$];
   logic [31:0] seed = 32'd58;
   int n_fail = 0;
   int total_checks = 0;
   htm_regs #(.IDENT_CODE(IDC), .FW_REVISION(FWR), .ID_VAR_BYTES(VARB)) DUT (.*);
   htm_master_model MDL (.i_clk(i_clk), .o_req(i_req), .o_we(i_we), .o_addr(i_addr),
      .o_wdata(i_wdata), .o_id_req(i_id_req));
   initial begin
      i_clk = 1'b0;
      forever #5 i_clk = ~i_clk;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [40:0] seen, input logic [40:0] want);
      total_checks++;
      if (seen !== want) begin
         n_fail++;
         $display("BAD at %0t: seen %h want %h", $time, seen, want);
      end
   endtask
   task automatic give_verdict();
      $display("Checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
      #1;
   endtask
   task automatic do_reset();
      i_arst_n = 1'b0;
      tick(8);
      i_arst_n = 1'b1;
      tick(3);
   endtask
   task automatic rd16(input logic [15:0] a, input logic [15:0] v);
      exp_q.push_back({1'b0, EXC_NONE, 16'h0, v});
      MDL.access(1'b0, a, 16'h0);
   endtask
   task automatic rdw(input logic [15:0] a, input logic [31:0] v);
      exp_q.push_back({1'b1, EXC_NONE, v});
      MDL.access(1'b0, a, 16'h0);
   endtask
   task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [7:0] e);
      exp_q.push_back({1'b0, e, 32'h0});
      MDL.access(1'b1, a, d);
   endtask
   task automatic link_is(input logic [28:0] want);
      check({12'h0, o_baud_sel, o_frame_fmt, o_node_addr, o_avg_period}, {12'h0, want});
   endtask
   // A second request while busy must be dropped
   task automatic id_seq(input logic [7:0] st);
      id_q = '{ID_FUNC, ID_COUNT, IDC[7:0], st, VARB[47:40], VARB[39:32], VARB[31:24],
         VARB[23:16], VARB[15:8], VARB[7:0]};
      MDL.ident();
      tick(3);
      MDL.ident();
      tick(12);
   endtask
   always @(negedge i_clk) begin
      if (o_ack === 1'b1 && exp_q.size() == 0) begin
         n_fail++;
         $display("BAD at %0t: unexpected answer", $time);
      end else if (o_ack === 1'b1) begin
         check({o_rdata_wide, o_exc, o_rdata}, exp_q.pop_front());
      end
      if (o_id_valid === 1'b1 && id_q.size() == 0) begin
         n_fail++;
         $display("BAD at %0t: extra id byte", $time);
      end else if (o_id_valid === 1'b1) begin
         check({33'h0, o_id_byte}, {33'h0, id_q.pop_front()});
      end
   end
   initial begin
      #50000;
      n_fail++;
      $display("BAD at %0t: timeout", $time);
      give_verdict();
   end
   initial begin
      i_arst_n = 1'b0;
      {i_calib_err, i_param_err, i_sensor_comm_err, i_avg_overrun, i_temp_comm_jumper} = 5'h0;
      for (int k = 0; k < NUM_FLOAT; k++) begin
         i_float_bank[32*k +: 32] = xs();
      end
      do_reset();
      link_is({DEF_BAUD, DEF_FMT, DEF_NODE, DEF_AVG});
      rd16(ADDR_STATUS, 16'h8000);
      wr(ADDR_STATUS, CLR_SUPPLY_RESET, EXC_NONE);
      rd16(ADDR_STATUS, 16'h0000);
      rd16(ADDR_IDENT, IDC);
      rd16(ADDR_FWREV, FWR);
      rd16(ADDR_COMMIT, 16'h0);
      wr(ADDR_FWREV, 16'h1, EXC_BAD_ADDR);
      wr(ADDR_IDENT, 16'h1, EXC_BAD_ADDR);
      wr(ADDR_IDENT - 16'h1, 16'h0, EXC_BAD_ADDR);
      wr(ADDR_SPARE_B + 16'h1, 16'h0, EXC_BAD_ADDR);
      wr(ADDR_SPARE_A, 16'h5, EXC_NONE);
      rd16(ADDR_SPARE_A, 16'h0);
      MDL.idle();
      {i_calib_err, i_param_err, i_sensor_comm_err, i_avg_overrun} = 4'hf;
      tick(2);
      rd16(ADDR_STATUS, 16'h6084);
      MDL.idle();
      id_seq(STATE_FAULT);
      {i_calib_err, i_param_err, i_sensor_comm_err, i_avg_overrun} = 4'h0;
      tick(3);
      id_seq(STATE_RUN);
      wr(ADDR_XCLR, 16'h0, EXC_NONE);
      wr(ADDR_XCLR, 16'h2, EXC_BAD_VALUE);
      MDL.idle();
      wr(ADDR_XCLR, FLAG_ONE, EXC_NONE);
      MDL.idle();
      rd16(ADDR_STATUS, 16'h0400);
      wr(ADDR_STATUS, CLR_XTREME_ERASED, EXC_NONE);
      rd16(ADDR_STATUS, 16'h0000);
      for (int c = 0; c < 6; c++) begin
         wr(ADDR_BAUD, c[15:0], c < 5 ? EXC_NONE : EXC_BAD_VALUE);
      end
      for (int c = 0; c < 5; c++) begin
         wr(ADDR_FMT, c[15:0], c < 4 ? EXC_NONE : EXC_BAD_VALUE);
      end
      wr(ADDR_NODE, 16'h0, EXC_BAD_VALUE);
      wr(ADDR_NODE, 16'h00f8, EXC_BAD_VALUE);
      wr(ADDR_NODE, 16'h0005, EXC_NONE);
      wr(ADDR_AVG, 16'h0005, EXC_BAD_VALUE);
      wr(ADDR_AVG, 16'h0e11, EXC_BAD_VALUE);
      wr(ADDR_AVG, 16'h0e10, EXC_NONE);
      wr(ADDR_COMMIT, 16'h2, EXC_BAD_VALUE);
      rd16(ADDR_BAUD, 16'h4);
      rd16(ADDR_FMT, 16'h3);
      rd16(ADDR_NODE, 16'h5);
      MDL.idle();
      tick(2);
      link_is({DEF_BAUD, DEF_FMT, DEF_NODE, 16'h0e10});
      wr(ADDR_COMMIT, 16'h0, EXC_NONE);
      MDL.idle();
      tick(2);
      link_is({DEF_BAUD, DEF_FMT, DEF_NODE, 16'h0e10});
      wr(ADDR_COMMIT, FLAG_ONE, EXC_NONE);
      MDL.idle();
      tick(2);
      link_is({HTM_BAUD_57600, HTM_FMT_8O1, 8'h05, 16'h0e10});
      wr(ADDR_RESTORE, 16'h2, EXC_BAD_VALUE);
      wr(ADDR_RESTORE, FLAG_ONE, EXC_NONE);
      MDL.idle();
      tick(2);
      link_is({DEF_BAUD, DEF_FMT, DEF_NODE, DEF_AVG});
      rd16(ADDR_NODE, {8'h0, DEF_NODE});
      for (int k = 0; k < NUM_FLOAT; k++) begin
         logic [31:0] f;
         logic [15:0] j;
         f = i_float_bank[32*k +: 32];
         j = k[15:0] << 1;
         rdw(FLOAT_BASE + k[15:0], f);
         rd16(MIRROR_HI_BASE + j, f[31:16]);
         rd16(MIRROR_HI_BASE + j + 16'h1, f[15:0]);
         rd16(MIRROR_LO_BASE + j, f[15:0]);
         rd16(MIRROR_LO_BASE + j + 16'h1, f[31:16]);
      end
      wr(FLOAT_BASE + 16'd12, 16'h1, EXC_BAD_ADDR);
      wr(FLOAT_BASE + 16'd13, 16'h0, EXC_BAD_ADDR);
      wr(MIRROR_HI_BASE + 16'd25, 16'h1, EXC_BAD_ADDR);
      wr(MIRROR_LO_BASE, 16'h1, EXC_BAD_ADDR);
      MDL.idle();
      i_temp_comm_jumper = 1'b1;
      tick(5);
      check({40'h0, o_temp_params_active}, 41'h1);
      link_is({JMP_BAUD, JMP_FMT, JMP_NODE, DEF_AVG});
      rd16(ADDR_STATUS, 16'h0200);
      rd16(ADDR_NODE, {8'h0, DEF_NODE});
      MDL.idle();
      i_temp_comm_jumper = 1'b0;
      tick(5);
      link_is({DEF_BAUD, DEF_FMT, DEF_NODE, DEF_AVG});
      do_reset();
      rd16(ADDR_STATUS, 16'h8000);
      MDL.idle();
      tick(3);
      check({9'h0, 32'(exp_q.size() + id_q.size())}, 41'h0);
      give_verdict();
   end
endmodule
bind htm_regs htm_regs_assertions #(.NUM_FLOAT(NUM_FLOAT)) CHK (.*);
